// ===== shared/shp_pkg.sv
/*
 * Constants for the sensor hub command engine: the bus address, the command
 * codes, the status codes, the sample layout and the reset values.
 * Assumes one 100 MHz system clock and that every user of the package writes
 * shp_pkg::name.
 */
package shp_pkg;

   // target address, write form; the read form is this value plus one
   localparam logic [7:0] ADDR_WR      = 8'haa;
   localparam logic [6:0] ADDR7        = ADDR_WR[7:1];

   // command families and indices
   localparam logic [7:0] FAM_STATUS   = 8'h00;
   localparam logic [7:0] FAM_MODE_RD  = 8'h02;
   localparam logic [7:0] FAM_OUT_CFG  = 8'h10;
   localparam logic [7:0] FAM_FIFO     = 8'h12;
   localparam logic [7:0] FAM_REG_WR   = 8'h40;
   localparam logic [7:0] FAM_REG_RD   = 8'h41;
   localparam logic [7:0] FAM_REG_ATTR = 8'h42;
   localparam logic [7:0] FAM_REG_DUMP = 8'h43;
   localparam logic [7:0] FAM_SENS_EN  = 8'h44;
   localparam logic [7:0] FAM_ALG_EN   = 8'h52;
   localparam logic [7:0] FAM_ID       = 8'hff;
   localparam logic [7:0] IDX_ZERO     = 8'h00;
   localparam logic [7:0] IDX_ONE      = 8'h01;
   localparam logic [7:0] IDX_ALG      = 8'h02;
   localparam logic [7:0] IDX_VERSION  = 8'h03;
   localparam logic [7:0] IDX_OPTICAL  = 8'h03;
   localparam logic [7:0] IDX_ACCEL    = 8'h04;
   localparam logic [7:0] OUT_RAW_ALG  = 8'h03;
   localparam logic [7:0] EN_MAX       = 8'h01;

   // status codes
   localparam logic [7:0] ST_OK        = 8'h00;
   localparam logic [7:0] ST_BAD_FAM   = 8'h01;
   localparam logic [7:0] ST_BAD_IDX   = 8'h02;
   localparam logic [7:0] ST_BAD_ARG   = 8'h03;
   localparam logic [7:0] PAD_BYTE     = 8'h00;

   // answers of the fixed queries
   localparam logic [7:0] MODE_APP     = 8'h00;
   localparam logic [7:0] VER_MAJOR    = 8'h01;
   localparam logic [7:0] VER_MINOR    = 8'h09;
   localparam logic [7:0] VER_REV      = 8'h00;
   localparam logic [7:0] REG_WIDTH    = 8'h01;
   localparam logic [7:0] REG_COUNT    = 8'h24;

   // hub status byte bits
   localparam int         RDY_BIT      = 3;
   localparam int         OVF_BIT      = 4;

   // output queue and sample layout: four 24-bit raw, hr 16, conf 8, spo2 16, state 8
   localparam int         SMP_BYTES    = 18;
   localparam int         SMP_BITS     = SMP_BYTES * 8;
   localparam logic [4:0] SMP_LAST     = 5'd17;
   localparam int         DEPTH        = 32;
   localparam logic [5:0] DEPTH_C      = 6'd32;
   localparam logic [9:0] SMP_BYTES_C  = 10'd18;
   localparam logic [7:0] THR_RESET    = 8'h01;

   typedef enum logic [2:0] {
      SS_IDLE, SS_ADDR, SS_AACK, SS_WR, SS_WACK, SS_RD, SS_RACK
   } shp_link_e;

   typedef enum logic [3:0] {
      RK_NONE, RK_MODE, RK_VER, RK_ATTR, RK_DUMP, RK_REG, RK_HUB, RK_CNT, RK_FIFO
   } shp_resp_e;

   typedef struct packed {
      logic            scl_m, scl_s, scl_p;
      logic            sda_m, sda_s, sda_p;
      shp_link_e       st;
      logic [3:0]      bcnt;
      logic [7:0]      sh;
      logic            rw;
      logic            drv;
      logic            wr_txn;
      logic [2:0]      wcnt;
      logic [3:0][7:0] cb;
      shp_resp_e       kind;
      logic [7:0]      stat;
      logic [9:0]      ridx;
      logic [9:0]      rlen;
      logic [4:0]      sbyte;
      logic [7:0]      mode;
      logic [7:0]      thr;
      logic            opt_en, acc_en, alg_en;
      logic            rdy, ovf;
      logic [7:0]      sreg_addr, sreg_wdata;
      logic            sreg_wr;
      logic [4:0]      wp, rp;
      logic [5:0]      cnt;
   } shp_state_s;

endpackage

// ===== src/shp_cmd_engine.sv
/*
 * Application-mode command engine of the sensor hub: a two-wire target that
 * takes family/index/argument writes and answers reads with a status byte and
 * payload, plus the output sample queue.
 * Assumes scl and the data line arrive asynchronously and the board pulls
 * them up; sensor register reads and sample inputs are on mclk.
 */
// Notes on behaviour
// - answer as target at write address 0xAA, reads at 0xAB.
// - read-mode returns status zero then mode byte zero.
// - version query returns status then major, minor and revision bytes.
// - attribute query returns status, register byte width, register count.
// - dump returns status then address/value pairs in ascending order.
// - single register read returns status and the current register value.
// - register write forwards value to the sensor, answers status only.
// - output format 0x03 selects raw plus algorithm samples, set before streaming.
// - threshold sets sample count at which data-ready rises.
// - enable command turns on optical sensor 0x03 or accelerometer 0x04.
// - hub status byte bit 3 shows output data ready.
// - hub status byte bit 4 shows output queue overflow.
// - count query returns status then samples held in the queue.
// - queue read sends samples back to back, removing each once sent.
// - sample holds 16-bit heart rate, 8-bit confidence, 16-bit saturation.
`timescale 1ns/1ns
module shp_cmd_engine (
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_n,
   output logic [7:0]       sreg_addr,
   output logic [7:0]       sreg_wdata,
   output logic             sreg_wr,
   input  wire logic [7:0]  sreg_rdata,
   input  wire logic        smp_valid,
   input  wire logic [23:0] smp_led1,
   input  wire logic [23:0] smp_led2,
   input  wire logic [23:0] smp_led3,
   input  wire logic [23:0] smp_led4,
   input  wire logic [15:0] smp_heart_rate,
   input  wire logic [7:0]  smp_confidence,
   input  wire logic [15:0] smp_spo2,
   input  wire logic [7:0]  smp_alg_state,
   output logic [7:0]       output_mode,
   output logic [7:0]       fifo_threshold,
   output logic             optical_en,
   output logic             accel_en,
   output logic             wrist_pulse_algorithm_en,
   output logic             output_ready_flag,
   output logic             output_queue_overflow_flag,
   output logic [5:0]       sample_count
);

   shp_pkg::shp_state_s          q;
   shp_pkg::shp_state_s          n;
   logic                         rst_meta_q;
   logic                         rst_n_q;
   logic [shp_pkg::SMP_BITS-1:0] mem [shp_pkg::DEPTH];
   logic [shp_pkg::SMP_BITS-1:0] smp_word;
   logic [shp_pkg::SMP_BITS-1:0] head_word;
   logic                         scl_rise, scl_fall, start_c, stop_c;
   logic                         push, pop, exec, advance;
   logic [7:0]                   cur_byte;
   logic [7:0]                   hub_byte;

   // only the optical sensor carries a register window
   function automatic logic sensor_ok(input logic [7:0] idx);
      return idx == shp_pkg::IDX_OPTICAL;
   endfunction

   // byte k of a sample, most significant first
   function automatic logic [7:0] smp_byte(input logic [shp_pkg::SMP_BITS-1:0] w,
                                           input logic [4:0] k);
      return w[shp_pkg::SMP_BITS - 8 - 8 * int'(k) +: 8];
   endfunction

   // release of reset through two flops
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // line events are taken only from the second and third sync stages
   assign scl_rise = q.scl_s & ~q.scl_p;
   assign scl_fall = ~q.scl_s & q.scl_p;
   assign start_c  = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
   assign stop_c   = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;

   // sample packing, raw channels first then algorithm fields
   assign smp_word  = {smp_led1, smp_led2, smp_led3, smp_led4,
                       smp_heart_rate, smp_confidence, smp_spo2, smp_alg_state};
   assign head_word = mem[q.rp];

   // byte the target will shift out next
   always_comb begin
      hub_byte                   = 8'h00;
      hub_byte[shp_pkg::RDY_BIT] = q.rdy;
      hub_byte[shp_pkg::OVF_BIT] = q.ovf;
      cur_byte = shp_pkg::PAD_BYTE;
      if (q.ridx >= q.rlen) begin
         cur_byte = shp_pkg::PAD_BYTE;
      end else if (q.ridx == 10'd0) begin
         cur_byte = q.stat;
      end else begin
         unique case (q.kind)
            shp_pkg::RK_MODE: cur_byte = shp_pkg::MODE_APP;
            shp_pkg::RK_VER: begin
               cur_byte = (q.ridx == 10'd1) ? shp_pkg::VER_MAJOR :
                          (q.ridx == 10'd2) ? shp_pkg::VER_MINOR : shp_pkg::VER_REV;
            end
            shp_pkg::RK_ATTR: begin
               cur_byte = (q.ridx == 10'd1) ? shp_pkg::REG_WIDTH : shp_pkg::REG_COUNT;
            end
            shp_pkg::RK_DUMP: cur_byte = q.ridx[0] ? q.sreg_addr : sreg_rdata;
            shp_pkg::RK_REG:  cur_byte = sreg_rdata;
            shp_pkg::RK_HUB:  cur_byte = hub_byte;
            shp_pkg::RK_CNT:  cur_byte = {2'b00, q.cnt};
            shp_pkg::RK_FIFO: cur_byte = smp_byte(head_word, q.sbyte);
            shp_pkg::RK_NONE: cur_byte = shp_pkg::PAD_BYTE;
         endcase
      end
   end

   // next state: link, command decode, response walk, queue
   always_comb begin
      n       = q;
      push    = 1'b0;
      pop     = 1'b0;
      exec    = 1'b0;
      advance = 1'b0;
      n.sreg_wr = 1'b0;
      n.scl_m = scl_i;
      n.scl_s = q.scl_m;
      n.scl_p = q.scl_s;
      n.sda_m = sda_i;
      n.sda_s = q.sda_m;
      n.sda_p = q.sda_s;

      // two-wire target; data changes only after scl falls
      if (start_c || stop_c) begin
         exec     = q.wr_txn && (q.wcnt != 3'd0);
         n.wr_txn = 1'b0;
         n.drv    = 1'b0;
         n.bcnt   = 4'd0;
         n.st     = start_c ? shp_pkg::SS_ADDR : shp_pkg::SS_IDLE;
      end else if (scl_rise) begin
         if ((q.st == shp_pkg::SS_ADDR || q.st == shp_pkg::SS_WR) && q.bcnt < 4'd8) begin
            n.sh   = {q.sh[6:0], q.sda_s};
            n.bcnt = q.bcnt + 4'd1;
         end else if (q.st == shp_pkg::SS_RACK) begin
            advance = 1'b1;
            if (q.sda_s) begin
               n.st = shp_pkg::SS_IDLE; // controller ended the read
            end
         end
      end else if (scl_fall) begin
         unique case (q.st)
            shp_pkg::SS_ADDR: begin
               if (q.bcnt == 4'd8) begin
                  if (q.sh[7:1] == shp_pkg::ADDR7) begin
                     n.st  = shp_pkg::SS_AACK;
                     n.drv = 1'b1;
                     n.rw  = q.sh[0];
                  end else begin
                     n.st = shp_pkg::SS_IDLE;
                  end
               end
            end
            shp_pkg::SS_WR: begin
               if (q.bcnt == 4'd8) begin
                  n.st  = shp_pkg::SS_WACK;
                  n.drv = 1'b1;
                  if (q.wcnt < 3'd4) begin
                     n.cb[q.wcnt[1:0]] = q.sh;
                  end
                  if (q.wcnt != 3'd5) begin
                     n.wcnt = q.wcnt + 3'd1; // saturates to flag an overlong command
                  end
               end
            end
            shp_pkg::SS_AACK, shp_pkg::SS_RACK: begin
               if (q.rw) begin
                  n.st   = shp_pkg::SS_RD;
                  n.sh   = cur_byte;
                  n.drv  = ~cur_byte[7];
                  n.bcnt = 4'd1;
               end else begin
                  n.st     = shp_pkg::SS_WR;
                  n.drv    = 1'b0;
                  n.bcnt   = 4'd0;
                  n.wr_txn = 1'b1;
                  n.wcnt   = 3'd0;
               end
            end
            shp_pkg::SS_WACK: begin
               n.st   = shp_pkg::SS_WR;
               n.drv  = 1'b0;
               n.bcnt = 4'd0;
            end
            shp_pkg::SS_RD: begin
               if (q.bcnt == 4'd8) begin
                  n.drv = 1'b0;
                  n.st  = shp_pkg::SS_RACK;
               end else begin
                  n.drv  = ~q.sh[3'd7 - q.bcnt[2:0]];
                  n.bcnt = q.bcnt + 4'd1;
               end
            end
            shp_pkg::SS_IDLE: n.st = shp_pkg::SS_IDLE;
         endcase
      end

      // a byte acknowledged or refused by the controller moves the response on
      if (advance && q.ridx < q.rlen) begin
         n.ridx = q.ridx + 10'd1;
         if (q.kind == shp_pkg::RK_FIFO && q.ridx != 10'd0) begin
            if (q.sbyte == shp_pkg::SMP_LAST) begin
               pop     = 1'b1;
               n.sbyte = 5'd0;
            end else begin
               n.sbyte = q.sbyte + 5'd1;
            end
         end
         if (q.kind == shp_pkg::RK_DUMP && q.ridx != 10'd0 && !q.ridx[0]) begin
            n.sreg_addr = q.sreg_addr + 8'd1;
         end
         if (q.kind == shp_pkg::RK_HUB && q.ridx == 10'd1) begin
            n.ovf = 1'b0; // read clears overflow; a new overflow below still wins
         end
      end

      // decode of a finished write, taken at the following stop or restart
      if (exec) begin
         n.ridx  = 10'd0;
         n.rlen  = 10'd1;
         n.sbyte = 5'd0;
         n.kind  = shp_pkg::RK_NONE;
         n.stat  = shp_pkg::ST_OK;
         unique case (q.cb[0])
            shp_pkg::FAM_STATUS, shp_pkg::FAM_MODE_RD: begin
               if (q.cb[1] != shp_pkg::IDX_ZERO) begin
                  n.stat = shp_pkg::ST_BAD_IDX;
               end else if (q.wcnt != 3'd2) begin
                  n.stat = shp_pkg::ST_BAD_ARG;
               end else begin
                  n.kind = (q.cb[0] == shp_pkg::FAM_STATUS) ? shp_pkg::RK_HUB
                                                            : shp_pkg::RK_MODE;
                  n.rlen = 10'd2;
               end
            end
            shp_pkg::FAM_OUT_CFG: begin
               if (q.wcnt != 3'd3) begin
                  n.stat = shp_pkg::ST_BAD_ARG;
               end else if (q.cb[1] == shp_pkg::IDX_ZERO && q.cb[2] <= shp_pkg::OUT_RAW_ALG) begin
                  n.mode = q.cb[2];
               end else if (q.cb[1] == shp_pkg::IDX_ONE) begin
                  n.thr = q.cb[2];
               end else begin
                  n.stat = (q.cb[1] == shp_pkg::IDX_ZERO) ? shp_pkg::ST_BAD_ARG
                                                          : shp_pkg::ST_BAD_IDX;
               end
            end
            shp_pkg::FAM_FIFO: begin
               if (q.wcnt != 3'd2) begin
                  n.stat = shp_pkg::ST_BAD_ARG;
               end else if (q.cb[1] == shp_pkg::IDX_ZERO) begin
                  n.kind = shp_pkg::RK_CNT;
                  n.rlen = 10'd2;
               end else if (q.cb[1] == shp_pkg::IDX_ONE) begin
                  n.kind = shp_pkg::RK_FIFO;
                  n.rlen = 10'(q.cnt) * shp_pkg::SMP_BYTES_C + 10'd1;
               end else begin
                  n.stat = shp_pkg::ST_BAD_IDX;
               end
            end
            shp_pkg::FAM_REG_WR, shp_pkg::FAM_REG_RD, shp_pkg::FAM_REG_ATTR,
            shp_pkg::FAM_REG_DUMP: begin
               if (!sensor_ok(q.cb[1])) begin
                  n.stat = shp_pkg::ST_BAD_IDX;
               end else if (q.cb[0] == shp_pkg::FAM_REG_WR && q.wcnt == 3'd4) begin
                  n.sreg_addr  = q.cb[2];
                  n.sreg_wdata = q.cb[3];
                  n.sreg_wr    = 1'b1;
               end else if (q.cb[0] == shp_pkg::FAM_REG_RD && q.wcnt == 3'd3) begin
                  n.sreg_addr = q.cb[2];
                  n.kind      = shp_pkg::RK_REG;
                  n.rlen      = 10'd2;
               end else if (q.cb[0] == shp_pkg::FAM_REG_ATTR && q.wcnt == 3'd2) begin
                  n.kind = shp_pkg::RK_ATTR;
                  n.rlen = 10'd3;
               end else if (q.cb[0] == shp_pkg::FAM_REG_DUMP && q.wcnt == 3'd2) begin
                  n.sreg_addr = 8'h00;
                  n.kind      = shp_pkg::RK_DUMP;
                  n.rlen      = {1'b0, shp_pkg::REG_COUNT, 1'b1};
               end else begin
                  n.stat = shp_pkg::ST_BAD_ARG;
               end
            end
            shp_pkg::FAM_SENS_EN: begin
               if (q.wcnt != 3'd3 || q.cb[2] > shp_pkg::EN_MAX) begin
                  n.stat = shp_pkg::ST_BAD_ARG;
               end else if (q.cb[1] == shp_pkg::IDX_OPTICAL) begin
                  n.opt_en = q.cb[2][0];
               end else if (q.cb[1] == shp_pkg::IDX_ACCEL) begin
                  n.acc_en = q.cb[2][0];
               end else begin
                  n.stat = shp_pkg::ST_BAD_IDX;
               end
            end
            shp_pkg::FAM_ALG_EN: begin
               if (q.cb[1] != shp_pkg::IDX_ALG) begin
                  n.stat = shp_pkg::ST_BAD_IDX;
               end else if (q.wcnt != 3'd3 || q.cb[2] > shp_pkg::EN_MAX) begin
                  n.stat = shp_pkg::ST_BAD_ARG;
               end else begin
                  n.alg_en = q.cb[2][0];
               end
            end
            shp_pkg::FAM_ID: begin
               if (q.cb[1] != shp_pkg::IDX_VERSION) begin
                  n.stat = shp_pkg::ST_BAD_IDX;
               end else if (q.wcnt != 3'd2) begin
                  n.stat = shp_pkg::ST_BAD_ARG;
               end else begin
                  n.kind = shp_pkg::RK_VER;
                  n.rlen = 10'd4;
               end
            end
            default: n.stat = shp_pkg::ST_BAD_FAM;
         endcase
      end

      // queue fill: samples count only once raw plus algorithm output is on
      if (smp_valid && q.opt_en && q.mode == shp_pkg::OUT_RAW_ALG) begin
         if (q.cnt == shp_pkg::DEPTH_C && !pop) begin
            n.ovf = 1'b1;
         end else begin
            push = 1'b1;
            n.wp = q.wp + 5'd1;
         end
      end
      if (pop) begin
         n.rp = q.rp + 5'd1;
      end
      n.cnt = q.cnt + {5'd0, push} - {5'd0, pop};
      n.rdy = (q.thr != 8'h00) && ({2'b00, n.cnt} >= q.thr);
   end

   // single state register
   always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         q     <= '0;
         q.thr <= shp_pkg::THR_RESET;
         {q.scl_m, q.scl_s, q.scl_p, q.sda_m, q.sda_s, q.sda_p} <= 6'h3f; // idle bus is high
      end else begin
         q <= n;
      end
   end

   // sample storage; no reset needed, contents gated by the count
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[q.wp] <= smp_word;
      end
   end

   // open-drain data line: only ever pulls low
   assign sda_o                      = 1'b0;
   assign sda_oe_n                   = ~q.drv;
   assign sreg_addr                  = q.sreg_addr;
   assign sreg_wdata                 = q.sreg_wdata;
   assign sreg_wr                    = q.sreg_wr;
   assign output_mode                = q.mode;
   assign fifo_threshold             = q.thr;
   assign optical_en                 = q.opt_en;
   assign accel_en                   = q.acc_en;
   assign wrist_pulse_algorithm_en   = q.alg_en;
   assign output_ready_flag          = q.rdy;
   assign output_queue_overflow_flag = q.ovf;
   assign sample_count               = q.cnt;

endmodule

// ===== verification/shp_cmd_engine_checker.sv
/* checker: timing relations between the command engine's ports.
   assumes it is bound onto shp_cmd_engine, one mclk domain */
`timescale 1ns/1ns
module shp_cmd_engine_checker (
   input logic       mclk,
   input logic       resetn,
   input logic       scl_i,
   input logic       smp_valid,
   input logic       sda_o,
   input logic       sda_oe_n,
   input logic       sreg_wr,
   input logic [7:0] output_mode,
   input logic [7:0] fifo_threshold,
   input logic       output_ready_flag,
   input logic       output_queue_overflow_flag,
   input logic [5:0] sample_count
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // open drain, and a move with the clock high would look like start or stop
   AST_SDA_LOW: assert property (sda_o == 1'b0)
      else $error("data line driven high");
   AST_OE_SCL: assert property ($changed(sda_oe_n) |-> !scl_i)
      else $error("data moved while bus clock high");
   // ready follows count against threshold once both have settled
   AST_RDY: assert property ($stable(sample_count) && $stable(fifo_threshold)
      |-> output_ready_flag == (sample_count >= fifo_threshold && fifo_threshold != 8'h00))
      else $error("ready flag wrong");
   AST_OVF: assert property ($rose(output_queue_overflow_flag)
      |-> $past(smp_valid) && $past(sample_count) == 6'd32) else $error("overflow without drop");
   AST_UP: assert property (sample_count > $past(sample_count)
      |-> $past(smp_valid) && sample_count == $past(sample_count) + 6'd1)
      else $error("count rise wrong");
   AST_DN: assert property (sample_count < $past(sample_count)
      |-> sample_count == $past(sample_count) - 6'd1) else $error("count fall wrong");
   // register writes are single pulses issued only after a stop or restart
   AST_WR_PULSE: assert property (sreg_wr |=> !sreg_wr)
      else $error("write pulse too long");
   AST_WR_STOP: assert property (sreg_wr |-> scl_i && $past(scl_i, 4))
      else $error("write not after stop");
   AST_MODE: assert property ($changed(output_mode) |-> output_mode <= 8'h03)
      else $error("bad output mode taken");
endmodule
bind shp_cmd_engine shp_cmd_engine_checker i_shp_cmd_engine_checker (
   .mclk(mclk), .resetn(resetn), .scl_i(scl_i), .smp_valid(smp_valid), .sda_o(sda_o),
   .sda_oe_n(sda_oe_n), .sreg_wr(sreg_wr), .output_mode(output_mode),
   .fifo_threshold(fifo_threshold), .output_ready_flag(output_ready_flag),
   .output_queue_overflow_flag(output_queue_overflow_flag), .sample_count(sample_count)
);

// ===== verification/shp_host_model.sv
/* host controller on the two-wire bus: clock and open-drain data pull.
   assumes a pull-up on the data wire; paced by mclk falling edges */
`timescale 1ns/1ns
module shp_host_model (
   input  wire logic mclk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_lo
);
   logic [7:0] rd [$];
   int         nacks = 0;
   initial scl = 1'b1;
   initial sda_lo = 1'b0;
   // the bus clock stands high between frames; 16 mclk a bit is 160 ns
   task automatic w(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // data moves a quarter bit after the fall, so it never races the clock edge
   task automatic bx(input logic b, output logic r);
      w(4);
      sda_lo = !b;
      w(4);
      scl = 1'b1;
      w(8);
      r = sda;
      scl = 1'b0;
   endtask
   // start or stop: data changes while the clock is high
   task automatic st(input logic stop);
      w(4);
      sda_lo = stop;
      w(4);
      scl = 1'b1;
      w(8);
      sda_lo = !stop;
      w(8);
      if (!stop) scl = 1'b0;
   endtask
   task automatic put(input logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bx(b[i], r);
      bx(1'b1, r);
      nacks += (r !== 1'b0);
   endtask
   // write nw bytes, stop, then read n bytes; the last one is refused
   task automatic cmd(input logic [31:0] c, input int nw, input int n);
      logic [7:0] b;
      logic       r;
      rd = {};
      st(1'b0);
      put(8'haa);
      for (int i = nw - 1; i >= 0; i--) put(c[8*i +: 8]);
      st(1'b1);
      st(1'b0);
      put(8'hab);
      for (int i = 0; i < n; i++) begin
         for (int j = 7; j >= 0; j--) bx(1'b1, b[j]);
         bx(i == n - 1, r);
         rd.push_back(b);
      end
      st(1'b1);
   endtask
endmodule

// ===== verification/shp_cmd_engine_tb.sv
/* bench for the command engine: host model on the bus, a sensor register
   file and a sample source on the side ports; checker is bound in */
`timescale 1ns/1ns
module shp_cmd_engine_tb;
   logic         mclk = 1'b0;
   logic         resetn = 1'b0;
   logic         smp_valid = 1'b0;
   logic [143:0] smp = '0;
   logic         scl, sda_lo, sda_o, sda_oe_n, sreg_wr;
   logic [7:0]   sreg_addr, sreg_wdata, output_mode, fifo_threshold;
   logic         optical_en, accel_en, alg_en, rdy, ovf;
   logic [5:0]   sample_count;
   logic [7:0]   regs [256];
   logic [31:0]  bad [3] = '{32'h7700, 32'h1205, 32'h100005};
   int           badn [3] = '{2, 2, 3};
   int           fails = 0;
   int           check_count = 0;
   int           cycles = 0;
   wire          sda = !(sda_lo || !sda_oe_n && !sda_o);
   always #5 mclk = !mclk;
   // sensor register file behind the pass-through port
   always @(posedge mclk) if (sreg_wr) regs[sreg_addr] <= sreg_wdata;
   shp_cmd_engine i_shp_cmd_engine (
      .mclk(mclk), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_n(sda_oe_n), .sreg_addr(sreg_addr), .sreg_wdata(sreg_wdata),
      .sreg_wr(sreg_wr), .sreg_rdata(regs[sreg_addr]), .smp_valid(smp_valid),
      .smp_led1(smp[143:120]), .smp_led2(smp[119:96]), .smp_led3(smp[95:72]),
      .smp_led4(smp[71:48]), .smp_heart_rate(smp[47:32]), .smp_confidence(smp[31:24]),
      .smp_spo2(smp[23:8]), .smp_alg_state(smp[7:0]), .output_mode(output_mode),
      .fifo_threshold(fifo_threshold), .optical_en(optical_en), .accel_en(accel_en),
      .wrist_pulse_algorithm_en(alg_en), .output_ready_flag(rdy),
      .output_queue_overflow_flag(ovf), .sample_count(sample_count)
   );
   shp_host_model i_shp_host_model (.mclk(mclk), .sda(sda), .scl(scl), .sda_lo(sda_lo));
   task automatic end_sim();
      if (fails == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one command and its whole answer, byte for byte
   task automatic expq(input string what, input logic [31:0] c, input int nw,
                       input logic [31:0] e, input int ne);
      i_shp_host_model.cmd(c, nw, ne);
      for (int i = 0; i < ne; i++) check(what, i_shp_host_model.rd[i], e[8*(ne-1-i) +: 8]);
   endtask
   function automatic logic [143:0] sval(input int k);
      for (int j = 0; j < 18; j++) sval[143-8*j -: 8] = 8'(k * 19 + j);
   endfunction
   task automatic push(input int k);
      @(negedge mclk);
      smp = sval(k);
      smp_valid = 1'b1;
      @(negedge mclk);
      smp_valid = 1'b0;
   endtask
   // a hang is cut short well above the expected 36.5k cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 90000) begin
         fails++;
         end_sim();
      end
   end
   initial begin
      for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'h5a;
      repeat (3) @(negedge mclk);
      resetn = 1'b1;
      repeat (6) @(negedge mclk);
      check("threshold", fifo_threshold, 8'h01);
      expq("mode", 32'h0200, 2, 32'h0000, 2);
      expq("version", 32'hff03, 2, 32'h00010900, 4);
      expq("attr", 32'h4203, 2, 32'h000124, 3);
      expq("reg write", 32'h40030d32, 4, 32'h00, 1);
      check("reg addr", sreg_addr, 8'h0d);
      check("reg data", sreg_wdata, 8'h32);
      expq("reg read", 32'h41030d, 3, 32'h0032, 2);
      expq("reg read", 32'h410307, 3, 32'h005d, 2);
      i_shp_host_model.cmd(32'h4303, 2, 74);
      check("dump", i_shp_host_model.rd[0], 8'h00);
      for (int a = 0; a < 36; a++) begin
         check("addr", i_shp_host_model.rd[2*a+1], 8'(a));
         check("value", i_shp_host_model.rd[2*a+2], a == 13 ? 8'h32 : 8'(a) ^ 8'h5a);
      end
      for (int i = 0; i < 3; i++) begin
         i_shp_host_model.cmd(bad[i], badn[i], 1);
         check("refusal", i_shp_host_model.rd[0], 8'(i + 1));
      end
      check("mode kept", output_mode, 8'h00);
      expq("out mode", 32'h100003, 3, 32'h00, 1);
      expq("threshold", 32'h100102, 3, 32'h00, 1);
      expq("optical", 32'h440301, 3, 32'h00, 1);
      expq("accel", 32'h440401, 3, 32'h00, 1);
      expq("algorithm", 32'h520201, 3, 32'h00, 1);
      check("mode", output_mode, 8'h03);
      check("threshold", fifo_threshold, 8'h02);
      check("enables", {optical_en, accel_en, alg_en}, 8'h07);
      // streaming: poll status, wait ready, query count, drain
      push(0);
      expq("status", 32'h0000, 2, 32'h0000, 2);
      push(1);
      expq("status", 32'h0000, 2, 32'h0008, 2);
      expq("count", 32'h1200, 2, 32'h0002, 2);
      i_shp_host_model.cmd(32'h1201, 2, 38);
      check("read status", i_shp_host_model.rd[0], 8'h00);
      for (int k = 0; k < 2; k++)
         for (int j = 0; j < 18; j++)
            check("sample", i_shp_host_model.rd[18*k+j+1], 8'(k * 19 + j));
      expq("count", 32'h1200, 2, 32'h0000, 2);
      for (int k = 0; k < 33; k++) push(k);
      check("full count", sample_count, 8'h20);
      check("flags", {rdy, ovf}, 8'h03);
      expq("status", 32'h0000, 2, 32'h001800, 3);
      check("flags", {rdy, ovf}, 8'h02);
      check("refused bytes", 8'(i_shp_host_model.nacks), 8'h00);
      end_sim();
   end
endmodule
